// File: udgs_defines.svh
/*
  register offsets, field positions, reset values and widths of the
  usb device global-state block.
  assumes an 8-bit byte address taken from the low bits of paddr.
*/
`ifndef UDGS_DEFINES_SVH
`define UDGS_DEFINES_SVH

// ****************************************
// offsets
// ****************************************
`define UDGS_OFF_FRAME   8'h00
`define UDGS_OFF_GLB     8'h04
`define UDGS_OFF_FADDR   8'h08
`define UDGS_OFF_IEN     8'h10
`define UDGS_OFF_IDIS    8'h14
`define UDGS_OFF_IMASK   8'h18
`define UDGS_OFF_ISTAT   8'h1C
`define UDGS_OFF_ICLR    8'h20
`define UDGS_OFF_EPRST   8'h28
`define UDGS_OFF_EPCS    8'h30
`define UDGS_OFF_EPFD    8'h50
`define UDGS_OFF_XCVR    8'h74

// ****************************************
// fields
// ****************************************
`define UDGS_FRM_W       11
`define UDGS_BIT_FERR    16
`define UDGS_BIT_FOK     17
`define UDGS_BIT_ADDR    0
`define UDGS_BIT_CONF    1
`define UDGS_BIT_SRE     2
`define UDGS_BIT_RSM     3
`define UDGS_BIT_RWK     4
`define UDGS_DEVADDR_W   7
`define UDGS_BIT_FUNC_EN 8
`define UDGS_IRQ_W       14
`define UDGS_BIT_HOST_RSM 9
`define UDGS_BIT_SOF     11
`define UDGS_BIT_ENDRST  12
`define UDGS_BIT_WAKE    13

// ****************************************
// reset values
// ****************************************
`define UDGS_RST_GLB     32'h0000_0010
`define UDGS_RST_FADDR   32'h0000_0100
`define UDGS_RST_IMASK   14'h1200
`define UDGS_RST_WORD    32'h0000_0000

`endif

// File: udgs_host_model.sv
/*
  behavioural model of the usb host side: start-of-frame packets,
  host resume and end of bus reset, as one-cycle strobes on pclk.
  assumes the caller starts each task right after a rising edge.
*/
`include "udgs_defines.svh"

module udgs_host_model
(
  input  wire logic                   pclk,
  output logic                        sof_pid_pulse,
  output logic                        frame_packet_end,
  output logic                        sof_crc_err,
  output logic [`UDGS_FRM_W-1:0]      sof_frame_in,
  output logic                        host_resume_irq,
  output logic                        bus_reset_end
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sof_pid_pulse = 1'b0;
    frame_packet_end = 1'b0;
    sof_crc_err = 1'b1;
    sof_frame_in = '1;
    host_resume_irq = 1'b0;
    bus_reset_end = 1'b0;
  end

  // ****************************************
  // packet strobes
  // ****************************************
  task automatic pid();
    @(posedge pclk);
    sof_pid_pulse <= 1'b1;
    @(posedge pclk);
    sof_pid_pulse <= 1'b0;
  endtask

  // frame and error mean nothing outside the strobe, so they flip afterwards
  task automatic eop(input logic [`UDGS_FRM_W-1:0] f, input logic e);
    @(posedge pclk);
    frame_packet_end <= 1'b1;
    sof_frame_in <= f;
    sof_crc_err <= e;
    @(posedge pclk);
    frame_packet_end <= 1'b0;
    sof_frame_in <= ~f;
    sof_crc_err <= ~e;
  endtask

  task automatic resume();
    @(posedge pclk);
    host_resume_irq <= 1'b1;
    @(posedge pclk);
    host_resume_irq <= 1'b0;
  endtask

  task automatic reset_end();
    @(posedge pclk);
    bus_reset_end <= 1'b1;
    @(posedge pclk);
    bus_reset_end <= 1'b0;
  endtask
endmodule // udgs_host_model

// File: udgs_pkg.sv
/*
  types of the usb device global-state block.
  assumes udgs_defines.svh is on the include path.
*/
package udgs_pkg;

  // ****************************************
  // apb access phase states, gray along the path
  // ****************************************
  typedef enum logic [0:0] {
    UDGS_IDLE = 1'b0,
    UDGS_ACK  = 1'b1
  } udgs_apb_t;

  typedef logic [31:0] udgs_word_t;

endpackage

// File: udgs_regs.sv
/*
  usb device global-state registers: frame capture, device state,
  remote wake-up, function address and the register map, on apb.
  assumes the link-side strobes are one-cycle pulses synchronous to pclk
  and that software keeps its own duties on the wake-up flags.
*/
`include "udgs_defines.svh"

// Functional notes
// - set wake and send-resume bits: device drives k-state
// - endpoint control words from 0x030 step four
// - endpoint fifo words from 0x050 step four
// - frame number captured at every sof end
// - frame error set at bad end, cleared pid
// - frame good set at clean end, cleared pid
// - sof status rises at pid, not end
// - address state: write one sets, reset clears
// - configured bit follows written value
// - send-resume enable gates wake and pin
// - resume in progress set on host resume with both enables set
// - k-state only when both enables set
// - seven-bit address, reset zero, firmware written
// - function enable bit resets to one and only drives function_enable_q
module udgs_regs
  import udgs_pkg::*;
#(
  parameter int NUM_EP = 4
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire udgs_pkg::udgs_word_t   pwdata,
  output logic                        pready_q,
  output udgs_pkg::udgs_word_t        prdata_q,
  input  wire logic                   sof_pid_pulse,
  input  wire logic                   frame_packet_end,
  input  wire logic                   sof_crc_err,
  input  wire logic [`UDGS_FRM_W-1:0] sof_frame_in,
  input  wire logic                   host_resume_irq,
  input  wire logic                   bus_reset_end,
  output logic                        kstate_drive_q,
  output logic                        send_resume_pin_en_q,
  output logic                        function_enable_q,
  output logic [`UDGS_DEVADDR_W-1:0]  device_address_q,
  output logic                        address_state_q,
  output logic                        configured_q
);
  import udgs_pkg::*;

  // ****************************************
  // parameter check
  // ****************************************
  generate
    if (NUM_EP < 1 || NUM_EP > 8)
    begin : g_bad_ep
      $error("NUM_EP must lie between 1 and 8");
    end
  endgenerate

  // ****************************************
  // apb slave
  // ****************************************
  udgs_apb_t apb_q;
  logic      acc;
  logic      wr_fire;
  logic      glb_wr;
  logic      fad_wr;
  udgs_word_t rd_d;

  assign acc     = psel && penable;
  assign wr_fire = ce && acc && pready_q && pwrite;
  assign glb_wr  = wr_fire && (paddr == `UDGS_OFF_GLB);
  assign fad_wr  = wr_fire && (paddr == `UDGS_OFF_FADDR);

  // one wait state keeps prdata straight from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_q    <= UDGS_IDLE;
      pready_q <= 1'b0;
      prdata_q <= `UDGS_RST_WORD;
    end
    else if (ce)
    begin
      case (apb_q)
        UDGS_IDLE:
        begin
          if (acc)
          begin
            apb_q    <= UDGS_ACK;
            pready_q <= 1'b1;
            prdata_q <= pwrite ? `UDGS_RST_WORD : rd_d;
          end
        end
        UDGS_ACK:
        begin
          apb_q    <= UDGS_IDLE;
          pready_q <= 1'b0;
        end
        default:
        begin
          apb_q    <= UDGS_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // frame number capture
  // ****************************************
  logic [`UDGS_FRM_W-1:0] frame_q;
  logic                   ferr_q;
  logic                   fok_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_q <= '0;
    else if (ce && frame_packet_end)
      frame_q <= sof_frame_in;
  end

  // the end of packet wins over a pid in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ferr_q <= 1'b0;
      fok_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (frame_packet_end)
      begin
        ferr_q <= sof_crc_err;
        fok_q  <= !sof_crc_err;
      end
      else if (sof_pid_pulse)
      begin
        ferr_q <= 1'b0;
        fok_q  <= 1'b0;
      end
    end
  end

  // ****************************************
  // global state
  // ****************************************
  logic resume_en_q;
  logic rsm_q;
  logic rwk_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      address_state_q <= 1'(`UDGS_RST_GLB >> `UDGS_BIT_ADDR);
      configured_q    <= 1'(`UDGS_RST_GLB >> `UDGS_BIT_CONF);
      resume_en_q     <= 1'(`UDGS_RST_GLB >> `UDGS_BIT_SRE);
      rwk_q           <= 1'(`UDGS_RST_GLB >> `UDGS_BIT_RWK);
    end
    else if (glb_wr)
    begin
      // a zero cannot leave address state
      if (pwdata[`UDGS_BIT_ADDR])
        address_state_q <= 1'b1;
      configured_q <= pwdata[`UDGS_BIT_CONF];
      resume_en_q  <= pwdata[`UDGS_BIT_SRE];
      rwk_q        <= pwdata[`UDGS_BIT_RWK];
    end
  end

  // resume seen while waking; dropped when software ends the wake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rsm_q <= 1'(`UDGS_RST_GLB >> `UDGS_BIT_RSM);
    else if (ce)
    begin
      if (host_resume_irq && rwk_q && resume_en_q)
        rsm_q <= 1'b1;
      else if (glb_wr && !pwdata[`UDGS_BIT_RWK])
        rsm_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kstate_drive_q       <= 1'b0;
      send_resume_pin_en_q <= 1'b0;
    end
    else if (ce)
    begin
      kstate_drive_q       <= rwk_q && resume_en_q;
      send_resume_pin_en_q <= resume_en_q;
    end
  end

  // ****************************************
  // function address
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      device_address_q  <= (`UDGS_DEVADDR_W)'(`UDGS_RST_FADDR);
      function_enable_q <= 1'(`UDGS_RST_FADDR >> `UDGS_BIT_FUNC_EN);
    end
    else if (fad_wr)
    begin
      device_address_q  <= pwdata[`UDGS_DEVADDR_W-1:0];
      function_enable_q <= pwdata[`UDGS_BIT_FUNC_EN];
    end
  end

  // ****************************************
  // interrupt mask and status
  // ****************************************
  logic [`UDGS_IRQ_W-1:0] imask_q;
  logic [`UDGS_IRQ_W-1:0] istat_q;
  logic [`UDGS_IRQ_W-1:0] iset;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      imask_q <= `UDGS_RST_IMASK;
    else if (wr_fire && paddr == `UDGS_OFF_IEN)
      imask_q <= imask_q | pwdata[`UDGS_IRQ_W-1:0];
    else if (wr_fire && paddr == `UDGS_OFF_IDIS)
      imask_q <= imask_q & ~pwdata[`UDGS_IRQ_W-1:0];
  end

  always_comb
  begin
    iset                  = '0;
    iset[`UDGS_BIT_SOF]   = sof_pid_pulse;
    iset[`UDGS_BIT_HOST_RSM] = host_resume_irq;
    iset[`UDGS_BIT_WAKE]     = host_resume_irq;
    iset[`UDGS_BIT_ENDRST]   = bus_reset_end;
  end

  // a new event beats a clear written in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      istat_q <= '0;
    else if (ce)
    begin
      if (wr_fire && paddr == `UDGS_OFF_ICLR)
        istat_q <= (istat_q & ~pwdata[`UDGS_IRQ_W-1:0]) | iset;
      else
        istat_q <= istat_q | iset;
    end
  end

  // ****************************************
  // plain storage: endpoint words, reset, transceiver
  // ****************************************
  udgs_word_t eprst_q;
  udgs_word_t xcvr_q;
  udgs_word_t epcs_q [NUM_EP];
  udgs_word_t epfd_q [NUM_EP];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eprst_q <= `UDGS_RST_WORD;
      xcvr_q  <= `UDGS_RST_WORD;
    end
    else if (wr_fire)
    begin
      if (paddr == `UDGS_OFF_EPRST)
        eprst_q <= pwdata;
      if (paddr == `UDGS_OFF_XCVR)
        xcvr_q <= pwdata;
    end
  end

  generate
    for (genvar e = 0; e < NUM_EP; e++)
    begin : g_ep
      localparam logic [7:0] CS_A = `UDGS_OFF_EPCS + 8'(4 * e);
      localparam logic [7:0] FD_A = `UDGS_OFF_EPFD + 8'(4 * e);
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          epcs_q[e] <= `UDGS_RST_WORD;
          epfd_q[e] <= `UDGS_RST_WORD;
        end
        else if (wr_fire)
        begin
          if (paddr == CS_A)
            epcs_q[e] <= pwdata;
          if (paddr == FD_A)
            epfd_q[e] <= pwdata;
        end
      end
    end
  endgenerate

  // ****************************************
  // read mux
  // ****************************************
  always_comb
  begin
    rd_d = '0;
    case (paddr)
      `UDGS_OFF_FRAME:
      begin
        rd_d[`UDGS_FRM_W-1:0] = frame_q;
        rd_d[`UDGS_BIT_FERR]  = ferr_q;
        rd_d[`UDGS_BIT_FOK]   = fok_q;
      end
      `UDGS_OFF_GLB:
      begin
        rd_d[`UDGS_BIT_ADDR] = address_state_q;
        rd_d[`UDGS_BIT_CONF] = configured_q;
        rd_d[`UDGS_BIT_SRE]  = resume_en_q;
        rd_d[`UDGS_BIT_RSM]  = rsm_q;
        rd_d[`UDGS_BIT_RWK]  = rwk_q;
      end
      `UDGS_OFF_FADDR:
      begin
        rd_d[`UDGS_DEVADDR_W-1:0] = device_address_q;
        rd_d[`UDGS_BIT_FUNC_EN]   = function_enable_q;
      end
      `UDGS_OFF_IMASK: rd_d[`UDGS_IRQ_W-1:0] = imask_q;
      `UDGS_OFF_ISTAT: rd_d[`UDGS_IRQ_W-1:0] = istat_q;
      `UDGS_OFF_EPRST: rd_d = eprst_q;
      `UDGS_OFF_XCVR:  rd_d = xcvr_q;
      default:
      begin
        for (int i = 0; i < NUM_EP; i++)
        begin
          if (paddr == `UDGS_OFF_EPCS + 8'(4 * i))
            rd_d = epcs_q[i];
          if (paddr == `UDGS_OFF_EPFD + 8'(4 * i))
            rd_d = epfd_q[i];
        end
      end
    endcase
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_frame_capture: assert property (
    ce && frame_packet_end |=> frame_q == $past(sof_frame_in))
    else $error("frame number not captured at packet end");

  a_ferr_set: assert property (
    ce && frame_packet_end && sof_crc_err |=> ferr_q && !fok_q)
    else $error("frame error not set on bad frame");

  a_fok_clear: assert property (
    ce && sof_pid_pulse && !frame_packet_end |=> !fok_q && !ferr_q)
    else $error("frame flags not cleared on pid");

  a_sof_status: assert property (
    ce && sof_pid_pulse |=> istat_q[`UDGS_BIT_SOF])
    else $error("sof status not raised at pid");

  a_addr_sticky: assert property (
    address_state_q |=> address_state_q)
    else $error("address state left without reset");

  a_conf_write: assert property (
    glb_wr |=> configured_q == $past(pwdata[`UDGS_BIT_CONF]))
    else $error("configured bit does not follow write");

  a_kstate_gate: assert property (
    ce && !(rwk_q && resume_en_q) |=> !kstate_drive_q)
    else $error("k-state driven without both enables");

  a_device_address_value_write: assert property (
    fad_wr |=> device_address_q == $past(pwdata[`UDGS_DEVADDR_W-1:0]))
    else $error("function address not loaded");

  a_resv_zero: assert property (
    ce && acc && !pready_q && !pwrite && paddr == 8'h0C |=> prdata_q == '0)
    else $error("reserved offset read not zero");

  a_wo_zero: assert property (
    ce && acc && !pready_q && !pwrite && paddr == `UDGS_OFF_ICLR
    |=> prdata_q == '0)
    else $error("write-only register read not zero");

  a_rsm_set: assert property (
    ce && host_resume_irq && rwk_q && resume_en_q |=> rsm_q)
    else $error("resume in progress not set");

endmodule // udgs_regs

// File: usb_device_global_state_regs_test.sv
/*
  self-checking bench of the global-state registers over apb.
  assumes udgs_host_model drives the link strobes.
*/
`include "udgs_defines.svh"

module usb_device_global_state_regs_test;
  import udgs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk, presetn, ce, psel, penable, pwrite;
  logic [7:0] paddr;
  udgs_word_t pwdata, prdata_q, d;
  logic pready_q, sof_pid_pulse, frame_packet_end, sof_crc_err, host_resume_irq;
  logic bus_reset_end, kstate_drive_q, send_resume_pin_en_q, function_enable_q;
  logic address_state_q, configured_q, e;
  logic [`UDGS_FRM_W-1:0] sof_frame_in, f, fr;
  logic [`UDGS_DEVADDR_W-1:0] device_address_q, fa;
  udgs_word_t exp_q[$];
  int bad_count, n_tests, cycles, seed;
  logic [7:0] holes[9] = '{8'h0C, 8'h24, 8'h2C, 8'h40, 8'h4C, 8'h60, 8'h70, 8'h78, 8'hFC};

  udgs_regs #(.NUM_EP(4)) udgs_regs_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready_q(pready_q), .prdata_q(prdata_q), .sof_pid_pulse(sof_pid_pulse),
    .frame_packet_end(frame_packet_end), .sof_crc_err(sof_crc_err),
    .sof_frame_in(sof_frame_in), .host_resume_irq(host_resume_irq),
    .bus_reset_end(bus_reset_end), .kstate_drive_q(kstate_drive_q),
    .send_resume_pin_en_q(send_resume_pin_en_q), .function_enable_q(function_enable_q),
    .device_address_q(device_address_q), .address_state_q(address_state_q),
    .configured_q(configured_q));

  udgs_host_model udgs_host_model_i (.pclk(pclk), .sof_pid_pulse(sof_pid_pulse),
    .frame_packet_end(frame_packet_end), .sof_crc_err(sof_crc_err),
    .sof_frame_in(sof_frame_in), .host_resume_irq(host_resume_irq),
    .bus_reset_end(bus_reset_end));

  // ****************************************
  // clock, timeout, report
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input udgs_word_t got, input udgs_word_t exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // every answer, read or write, pops one note; writes answer zero
  always @(negedge pclk)
    if (pready_q === 1'b1)
      chk(prdata_q, exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_BEEF);

  // ****************************************
  // apb master
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] a, input udgs_word_t wd,
                     input udgs_word_t ex);
    exp_q.push_back(wr ? 32'h0 : ex);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_q !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(negedge pclk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'hC860;
    fr = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 32'h0);
    apb(1'b0, 8'h04, 32'h0, 32'h0000_0010);
    apb(1'b0, 8'h08, 32'h0, 32'h0000_0100);
    apb(1'b0, 8'h18, 32'h0, 32'h0000_1200);
    chk(32'(function_enable_q), 32'h1);
    apb(1'b0, 8'h10, 32'h0, 32'h0);
    apb(1'b0, 8'h14, 32'h0, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 32'h0);
    foreach (holes[i])
    begin
      apb(1'b1, holes[i], 32'hFFFF_FFFF, 32'h0);
      apb(1'b0, holes[i], 32'h0, 32'h0);
    end
    for (int n = 0; n < 4; n++)
    begin
      d = $random(seed);
      apb(1'b1, 8'(8'h30 + 4 * n), d, 32'h0);
      apb(1'b1, 8'(8'h50 + 4 * n), ~d, 32'h0);
      apb(1'b0, 8'(8'h30 + 4 * n), 32'h0, d);
      apb(1'b0, 8'(8'h50 + 4 * n), 32'h0, ~d);
    end
    apb(1'b1, 8'h14, 32'h0000_3FFF, 32'h0);
    apb(1'b1, 8'h10, 32'h0000_0800, 32'h0);
    apb(1'b0, 8'h18, 32'h0, 32'h0000_0800);
    // address first, then the address state
    fa = 7'($random(seed));
    apb(1'b1, 8'h08, {25'h0, fa}, 32'h0);
    apb(1'b0, 8'h08, 32'h0, {25'h0, fa});
    chk(32'(function_enable_q), 32'h0);
    apb(1'b1, 8'h08, {23'h0, 1'b1, 1'b0, fa}, 32'h0);
    apb(1'b1, 8'h04, 32'h1, 32'h0);
    apb(1'b1, 8'h04, 32'h2, 32'h0);
    apb(1'b0, 8'h04, 32'h0, 32'h3);
    chk({configured_q, address_state_q, function_enable_q, device_address_q},
        {22'h0, 3'b111, fa});
    apb(1'b1, 8'h04, 32'h0, 32'h0);
    apb(1'b0, 8'h04, 32'h0, 32'h1);
    // remote wake: both enables, then each alone
    apb(1'b1, 8'h04, 32'h15, 32'h0);
    settle();
    chk({kstate_drive_q, send_resume_pin_en_q}, 32'h3);
    apb(1'b1, 8'h20, 32'h0000_3FFF, 32'h0);
    udgs_host_model_i.resume();
    apb(1'b0, 8'h04, 32'h0, 32'h1D);
    apb(1'b0, 8'h1C, 32'h0, 32'h0000_2200);
    apb(1'b1, 8'h20, 32'h0000_3FFF, 32'h0);
    apb(1'b1, 8'h04, 32'h5, 32'h0);
    settle();
    chk({kstate_drive_q, send_resume_pin_en_q}, 32'h1);
    apb(1'b1, 8'h04, 32'h11, 32'h0);
    settle();
    chk({kstate_drive_q, send_resume_pin_en_q}, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, 32'h0);
    // frames: clean, bad, clean; flags drop at the pid
    for (int k = 0; k < 3; k++)
    begin
      f = 11'($random(seed));
      e = k[0];
      udgs_host_model_i.pid();
      apb(1'b0, 8'h00, 32'h0, {21'h0, fr});
      apb(1'b0, 8'h1C, 32'h0, 32'h0000_0800);
      udgs_host_model_i.eop(f, e);
      fr = f;
      apb(1'b0, 8'h00, 32'h0, {14'h0, ~e, e, 5'h0, f});
      apb(1'b1, 8'h20, 32'h0000_3FFF, 32'h0);
    end
    udgs_host_model_i.reset_end();
    apb(1'b0, 8'h1C, 32'h0, 32'h0000_1000);
    // link strobes are lost while the clock enable is low
    @(posedge pclk);
    ce <= 1'b0;
    udgs_host_model_i.resume();
    udgs_host_model_i.pid();
    ce <= 1'b1;
    apb(1'b0, 8'h1C, 32'h0, 32'h0000_1000);
    apb(1'b0, 8'h00, 32'h0, {14'h0, 1'b1, 1'b0, 5'h0, fr});
    // only a reset leaves the address state
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0, 32'h0000_0010);
    apb(1'b0, 8'h08, 32'h0, 32'h0000_0100);
    repeat (3) @(posedge pclk);
    wrap_up();
  end
endmodule // usb_device_global_state_regs_test
